//--- rtl/acs_ctrl.sv
// comparator pair control: status, status clear, revision, input routing over apb
//
// Functional notes
// - a result high while positive above negative
// - b comparison-enabled bit reflects state
// - a comparison-enabled bit reflects state
// - window-enabled bit reflects state
// - b enabled bit reflects state
// - a enabled bit reflects state
// - b startup-done pending set after startup
// - a startup-done pending set after startup
// - window interrupt pending flag held
// - b interrupt pending flag held
// - a interrupt pending flag held
// - writing one to clear drops flag
// - writing zero to clear does nothing
// - revision register holds 12-bit revision
// - variant field reserved, no behaviour
// - runs on its own bus clock
// - one instance manages one comparator pair
// - unit zero a input select mapping
// - unit zero b input select mapping
// - unit one a positive select mapping (UNIT is unused; unit one uses the unit zero tables)
// - b result high while positive above negative
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl #(
  parameter logic UNIT = 1'b0, // 0: comparators zero-a/b, 1: one-a/b
  parameter logic [11:0] REVISION = 12'h0a5, // arbitrary value
  parameter logic [3:0] VARIANT = 4'h0 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire logic cmp_a_raw,
  input wire logic cmp_b_raw,
  input wire logic window_raw,
  input wire logic cmp_a_sut_done,
  input wire logic cmp_b_sut_done,
  input wire logic cmp_a_irq_event,
  input wire logic cmp_b_irq_event,
  input wire logic window_irq_event,
  // to analog macro
  output logic cmp_a_on,
  output logic cmp_b_on,
  output logic window_on,
  output logic cmp_a_compare_on,
  output logic cmp_b_compare_on,
  output logic [6:0] cmp_a_pos_route,
  output logic [6:0] cmp_a_neg_route,
  output logic [6:0] cmp_b_pos_route,
  output logic [6:0] cmp_b_neg_route,
  output logic irq_req
);
  // =========================================
  // routing decode functions
  // a positive: pins 0-1, dac0 at code 2
  function automatic logic [6:0] route_a_p(input logic [2:0] c);
    logic [6:0] r;
    r = 7'h00;
    if (c == acs_pkg::SEL_PIN0 || c == acs_pkg::SEL_PIN1) begin
      r[c] = 1'b1;
    end else if (c == acs_pkg::A_P_DAC0) begin
      r[acs_pkg::SRC_DAC0] = 1'b1;
    end
    return r;
  endfunction : route_a_p
  // a negative: pins 0-3, supply 4, dac1 5
  function automatic logic [6:0] route_a_n(input logic [2:0] c);
    logic [6:0] r;
    r = 7'h00;
    if (c <= acs_pkg::SEL_PIN3) begin
      r[c] = 1'b1;
    end else if (c == acs_pkg::A_N_SUPPLY) begin
      r[acs_pkg::SRC_SUPPLY] = 1'b1;
    end else if (c == acs_pkg::A_N_DAC1) begin
      r[acs_pkg::SRC_DAC1] = 1'b1;
    end
    return r;
  endfunction : route_a_n
  // b positive: pins 0-3, dac0 4, supply 5
  function automatic logic [6:0] route_b_p(input logic [2:0] c);
    logic [6:0] r;
    r = 7'h00;
    if (c <= acs_pkg::SEL_PIN3) begin
      r[c] = 1'b1;
    end else if (c == acs_pkg::B_P_DAC0) begin
      r[acs_pkg::SRC_DAC0] = 1'b1;
    end else if (c == acs_pkg::B_P_SUPPLY) begin
      r[acs_pkg::SRC_SUPPLY] = 1'b1;
    end
    return r;
  endfunction : route_b_p
  // b negative: pins 0-1, dac1 2
  function automatic logic [6:0] route_b_n(input logic [2:0] c);
    logic [6:0] r;
    r = 7'h00;
    if (c == acs_pkg::SEL_PIN0 || c == acs_pkg::SEL_PIN1) begin
      r[c] = 1'b1;
    end else if (c == acs_pkg::B_N_DAC1) begin
      r[acs_pkg::SRC_DAC1] = 1'b1;
    end
    return r;
  endfunction : route_b_n
  // =========================================
  // bus decode
  logic wr_acc; // write in access phase
  logic rd_acc; // read in access phase
  logic [31:0] ctrl_reg; // control register
  logic [4:0] pend_reg; // pending flags
  logic [4:0] clr_mask; // clear write this cycle
  logic [4:0] set_mask; // hardware or injected events
  logic [4:0] evset_mask; // software injected events
  logic a_res_reg; // registered a result
  logic b_res_reg; // registered b result
  logic w_res_reg; // registered window result
  logic a_rdy_reg; // a ready
  logic b_rdy_reg; // b ready
  logic [31:0] status_w; // status word
  logic [31:0] rev_w; // revision word
  logic mapped; // address known

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == acs_pkg::OFF_STATUS) || (paddr == acs_pkg::OFF_CLEAR) ||
                  (paddr == acs_pkg::OFF_REV) || (paddr == acs_pkg::OFF_CTRL) ||
                  (paddr == acs_pkg::OFF_EVSET);

  // =========================================
  // control register
  // software write steers enables and routing
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= acs_pkg::CTRL_RST;
    end else if (wr_acc && paddr == acs_pkg::OFF_CTRL) begin
      ctrl_reg <= pwdata;
    end
  end

  // enable outputs follow control
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_a_on <= 1'b0;
      cmp_b_on <= 1'b0;
      window_on <= 1'b0;
      cmp_a_compare_on <= 1'b0;
      cmp_b_compare_on <= 1'b0;
    end else begin
      cmp_a_on <= ctrl_reg[acs_pkg::C_A_ON];
      cmp_b_on <= ctrl_reg[acs_pkg::C_B_ON];
      window_on <= ctrl_reg[acs_pkg::C_WIN_ON];
      cmp_a_compare_on <= ctrl_reg[acs_pkg::C_A_CMP];
      cmp_b_compare_on <= ctrl_reg[acs_pkg::C_B_CMP];
    end
  end

  // =========================================
  // input routing per instance
  // both units use the same tables; UNIT does not change the routing
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_a_pos_route <= 7'h00;
      cmp_a_neg_route <= 7'h00;
      cmp_b_pos_route <= 7'h00;
      cmp_b_neg_route <= 7'h00;
    end else begin
      cmp_a_pos_route <= route_a_p(ctrl_reg[acs_pkg::C_A_SELP +: acs_pkg::SEL_W]);
      cmp_a_neg_route <= route_a_n(ctrl_reg[acs_pkg::C_A_SELN +: acs_pkg::SEL_W]);
      cmp_b_pos_route <= route_b_p(ctrl_reg[acs_pkg::C_B_SELP +: acs_pkg::SEL_W]);
      cmp_b_neg_route <= route_b_n(ctrl_reg[acs_pkg::C_B_SELN +: acs_pkg::SEL_W]);
    end
  end

  // =========================================
  // live results, registered from raw inputs, not gated by comparison enable
  always_ff @(posedge clk) begin
    if (rst) begin
      a_res_reg <= 1'b0;
      b_res_reg <= 1'b0;
      w_res_reg <= 1'b0;
    end else begin
      a_res_reg <= cmp_a_raw;
      b_res_reg <= cmp_b_raw;
      w_res_reg <= window_raw;
    end
  end

  // ready: enabled and startup seen
  always_ff @(posedge clk) begin
    if (rst) begin
      a_rdy_reg <= 1'b0;
      b_rdy_reg <= 1'b0;
    end else begin
      a_rdy_reg <= cmp_a_on && (a_rdy_reg || cmp_a_sut_done);
      b_rdy_reg <= cmp_b_on && (b_rdy_reg || cmp_b_sut_done);
    end
  end

  // =========================================
  // pending flags
  assign clr_mask = (wr_acc && paddr == acs_pkg::OFF_CLEAR) ?
                    pwdata[acs_pkg::PEND_W-1:0] : 5'h00;
  assign evset_mask = (wr_acc && paddr == acs_pkg::OFF_EVSET) ?
                      pwdata[acs_pkg::PEND_W-1:0] : 5'h00;
  always_comb begin
    set_mask = evset_mask;
    set_mask[acs_pkg::P_A_IRQ] = set_mask[acs_pkg::P_A_IRQ] | cmp_a_irq_event;
    set_mask[acs_pkg::P_B_IRQ] = set_mask[acs_pkg::P_B_IRQ] | cmp_b_irq_event;
    set_mask[acs_pkg::P_WIN] = set_mask[acs_pkg::P_WIN] | window_irq_event;
    set_mask[acs_pkg::P_A_SUT] = set_mask[acs_pkg::P_A_SUT] | (cmp_a_sut_done && cmp_a_on);
    set_mask[acs_pkg::P_B_SUT] = set_mask[acs_pkg::P_B_SUT] | (cmp_b_sut_done && cmp_b_on);
  end

  // set wins over clear so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 5'h00;
    end else begin
      pend_reg <= (pend_reg & ~clr_mask) | set_mask;
    end
  end

  // interrupt request withdrawn with its flag
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |((pend_reg & ~clr_mask) | set_mask);
    end
  end

  // =========================================
  // read words
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[acs_pkg::PEND_W-1:0] = pend_reg;
    status_w[acs_pkg::S_A_ON] = cmp_a_on;
    status_w[acs_pkg::S_B_ON] = cmp_b_on;
    status_w[acs_pkg::S_WIN_ON] = window_on;
    status_w[acs_pkg::S_A_CMP] = cmp_a_compare_on;
    status_w[acs_pkg::S_B_CMP] = cmp_b_compare_on;
    status_w[acs_pkg::S_A_RES] = a_res_reg;
    status_w[acs_pkg::S_B_RES] = b_res_reg;
    status_w[acs_pkg::S_W_RES] = w_res_reg;
    status_w[acs_pkg::S_A_RDY] = a_rdy_reg;
    status_w[acs_pkg::S_B_RDY] = b_rdy_reg;
    status_w[acs_pkg::S_W_RDY] = a_rdy_reg && b_rdy_reg;
  end

  // revision word; variant reserved, fixed
  always_comb begin
    rev_w = 32'h0000_0000;
    rev_w[acs_pkg::REV_W-1:0] = REVISION;
    rev_w[acs_pkg::VARIANT_LSB +: acs_pkg::VARIANT_W] = VARIANT;
  end

  // =========================================
  // apb answer: zero wait, registered data
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          acs_pkg::OFF_STATUS: prdata <= status_w;
          acs_pkg::OFF_REV: prdata <= rev_w;
          acs_pkg::OFF_CTRL: prdata <= ctrl_reg;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // =========================================
  // checks
  a_clear_drops: assert property (@(posedge clk) disable iff (rst)
    (clr_mask[acs_pkg::P_A_IRQ] && !set_mask[acs_pkg::P_A_IRQ]) |=> !pend_reg[acs_pkg::P_A_IRQ])
    else $error("clear did not drop a flag");
  a_zero_keeps: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == acs_pkg::OFF_CLEAR && pwdata[4:0] == 5'h00) |=>
    ((pend_reg & $past(pend_reg)) == $past(pend_reg)))
    else $error("zero clear changed flags");
  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    (clr_mask[acs_pkg::P_WIN] && window_irq_event) |=> pend_reg[acs_pkg::P_WIN])
    else $error("event lost on clear");
  a_b_sut_set: assert property (@(posedge clk) disable iff (rst)
    (cmp_b_sut_done && cmp_b_on) |=> pend_reg[acs_pkg::P_B_SUT])
    else $error("b startup flag not set");
  a_a_sut_set: assert property (@(posedge clk) disable iff (rst)
    (cmp_a_sut_done && cmp_a_on) |=> pend_reg[acs_pkg::P_A_SUT])
    else $error("a startup flag not set");
  a_a_result: assert property (@(posedge clk) disable iff (rst)
    cmp_a_raw |=> a_res_reg)
    else $error("a result not tracked");
  a_b_result: assert property (@(posedge clk) disable iff (rst)
    !cmp_b_raw |=> !b_res_reg)
    else $error("b result not tracked");
  a_win_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == acs_pkg::OFF_CTRL) |=> ##1 window_on == $past(pwdata[acs_pkg::C_WIN_ON], 2))
    else $error("window enable not applied");
  a_rev_read: assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == acs_pkg::OFF_REV) |=>
    prdata[acs_pkg::REV_W-1:0] == REVISION)
    else $error("revision read wrong");
endmodule : acs_ctrl
`default_nettype wire

//--- pkg/acs_pkg.sv
// package of register map, field positions and mux encodings for the comparator status block
package acs_pkg;
  // =========================================
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h40; // comparator status, read-only
  localparam logic [7:0] OFF_CLEAR = 8'h44; // status clear, write-only
  localparam logic [7:0] OFF_REV = 8'h48; // module revision, read-only
  localparam logic [7:0] OFF_CTRL = 8'h4c; // enable/select control, read-write
  localparam logic [7:0] OFF_EVSET = 8'h50; // software event injection, write-only
  // =========================================
  // pending flag positions (status bits 4:0, clear bits 4:0)
  localparam int PEND_W = 5;
  localparam int P_A_IRQ = 0;
  localparam int P_B_IRQ = 1;
  localparam int P_WIN = 2;
  localparam int P_A_SUT = 3;
  localparam int P_B_SUT = 4;
  // enable field positions in status
  localparam int S_A_ON = 8;
  localparam int S_B_ON = 9;
  localparam int S_WIN_ON = 10;
  localparam int S_A_CMP = 11;
  localparam int S_B_CMP = 12;
  // live result and ready positions in status
  localparam int S_A_RES = 16;
  localparam int S_B_RES = 17;
  localparam int S_W_RES = 18;
  localparam int S_A_RDY = 24;
  localparam int S_B_RDY = 25;
  localparam int S_W_RDY = 26;
  // =========================================
  // control register layout
  localparam int C_A_ON = 0;
  localparam int C_B_ON = 1;
  localparam int C_WIN_ON = 2;
  localparam int C_A_CMP = 3;
  localparam int C_B_CMP = 4;
  localparam int C_A_SELP = 8;
  localparam int C_A_SELN = 12;
  localparam int C_B_SELP = 16;
  localparam int C_B_SELN = 20;
  localparam int SEL_W = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // =========================================
  // revision register
  localparam int REV_W = 12;
  localparam int VARIANT_LSB = 16;
  localparam int VARIANT_W = 4;
  // =========================================
  // input select codes (unit zero)
  localparam logic [2:0] SEL_PIN0 = 3'h0;
  localparam logic [2:0] SEL_PIN1 = 3'h1;
  localparam logic [2:0] SEL_PIN2 = 3'h2;
  localparam logic [2:0] SEL_PIN3 = 3'h3;
  localparam logic [2:0] A_P_DAC0 = 3'h2; // first dac internal out
  localparam logic [2:0] A_N_SUPPLY = 3'h4; // scaled analog supply
  localparam logic [2:0] A_N_DAC1 = 3'h5; // second dac internal out
  localparam logic [2:0] B_P_DAC0 = 3'h4;
  localparam logic [2:0] B_P_SUPPLY = 3'h5;
  localparam logic [2:0] B_N_DAC1 = 3'h2;
  // one-hot source routing: pins 0..3, dac0, dac1, supply
  localparam int SRC_W = 7;
  localparam int SRC_DAC0 = 4;
  localparam int SRC_DAC1 = 5;
  localparam int SRC_SUPPLY = 6;
endpackage : acs_pkg

//--- tb/acs_cmp_model.sv
// behavioural comparator pair: live outputs and startup-done pulses
`timescale 1ns/1ps
`default_nettype none
module acs_cmp_model #(
  parameter int SUT_CYC = 20 // startup time in cycles, shortened
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // enables from the block
  input wire logic cmp_a_on,
  input wire logic cmp_b_on,
  // input levels commanded by the bench: a, b, window
  input wire logic [2:0] lvl,
  // comparator outputs
  output logic cmp_a_raw,
  output logic cmp_b_raw,
  output logic window_raw,
  output logic cmp_a_sut_done,
  output logic cmp_b_sut_done
);
  int cnt_a; // cycles since a was switched on
  int cnt_b; // cycles since b was switched on
  // outputs follow the input levels
  assign cmp_a_raw = lvl[0];
  assign cmp_b_raw = lvl[1];
  assign window_raw = lvl[2];
  // one pulse when the startup time is over
  assign cmp_a_sut_done = (cnt_a == SUT_CYC);
  assign cmp_b_sut_done = (cnt_b == SUT_CYC);
  // =========================================
  // startup counters, restart while switched off
  always_ff @(posedge clk) begin
    if (rst || !cmp_a_on) cnt_a <= 0;
    else if (cnt_a <= SUT_CYC) cnt_a <= cnt_a + 1;
    if (rst || !cmp_b_on) cnt_b <= 0;
    else if (cnt_b <= SUT_CYC) cnt_b <= cnt_b + 1;
  end
endmodule : acs_cmp_model
`default_nettype wire

//--- tb/acs_ctrl_tb.sv
// self-checking bench of the comparator status block
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr; // bus and clock
  logic [7:0] paddr; // byte address
  logic [31:0] pwdata, prdata, rd; // bus data, last read
  logic er; // last error response
  logic a_raw, b_raw, w_raw, a_sut, b_sut; // comparator side
  logic [2:0] lvl, ev; // commanded levels and interrupt events
  logic [4:0] en; // enable outputs, control bit order
  logic [6:0] ap, an, bp, bn; // routing outputs
  logic irq; // interrupt request
  logic [7:0] seed; // random state
  logic [4:0] pend; // expected pending flags
  int mismatches, cmp_count;
  // =========================================
  // design and comparator model
  acs_ctrl #(.UNIT(1'b0), .REVISION(12'h3c7), .VARIANT(4'h0)) acs_ctrl_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_a_raw(a_raw), .cmp_b_raw(b_raw), .window_raw(w_raw),
    .cmp_a_sut_done(a_sut), .cmp_b_sut_done(b_sut), .cmp_a_irq_event(ev[0]),
    .cmp_b_irq_event(ev[1]), .window_irq_event(ev[2]), .cmp_a_on(en[0]),
    .cmp_b_on(en[1]), .window_on(en[2]), .cmp_a_compare_on(en[3]),
    .cmp_b_compare_on(en[4]), .cmp_a_pos_route(ap), .cmp_a_neg_route(an),
    .cmp_b_pos_route(bp), .cmp_b_neg_route(bn), .irq_req(irq));
  acs_cmp_model #(.SUT_CYC(20)) acs_cmp_model_i (
    .clk(clk), .rst(rst), .cmp_a_on(en[0]), .cmp_b_on(en[1]), .lvl(lvl),
    .cmp_a_raw(a_raw), .cmp_b_raw(b_raw), .window_raw(w_raw),
    .cmp_a_sut_done(a_sut), .cmp_b_sut_done(b_sut));
  // =========================================
  // helpers: random source, routing expectation, compare, bus cycle
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // expected one-hot route of field f (0 a pos, 1 a neg, 2 b pos, 3 b neg)
  function automatic logic [6:0] route_exp(input logic [1:0] f, input logic [2:0] c);
    logic [2:0] lim;
    lim = (f == 2'h0 || f == 2'h3) ? 3'h1 : 3'h3;
    case ({f, c})
      5'h02: return 7'h10; // first dac
      5'h0c: return 7'h40; // scaled supply
      5'h0d: return 7'h20; // second dac
      5'h14: return 7'h10; // first dac
      5'h15: return 7'h40; // scaled supply
      5'h1a: return 7'h20; // second dac
      default: return (c <= lim) ? (7'h01 << c) : 7'h00; // pins or unlisted
    endcase
  endfunction : route_exp
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : apb
  // =========================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // =========================================
  // main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, lvl, ev} = {1'b1, 3'h0, 8'h0, 32'h0, 6'h0};
    {mismatches, cmp_count, seed} = {32'd0, 32'd0, 8'd66};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset contents, revision, refused address
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, acs_pkg::OFF_REV, 32'h0);
    chk("revision", 32'h0000_03c7, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    // each enable alone, register bit and pin
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, acs_pkg::OFF_CTRL, 32'h1 << i);
      apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
      chk("enable bits", 32'h1 << i, {27'h0, rd[12:8]});
      chk("enable pins", 32'h1 << i, {27'h0, en});
    end
    // startup: nothing pending at switch-on, both flags after the time
    apb(1'b1, acs_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, acs_pkg::OFF_CLEAR, 32'h1f);
    apb(1'b1, acs_pkg::OFF_CTRL, 32'h1f);
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("startup early", 32'h0, {30'h0, rd[4:3]});
    repeat (24) @(posedge clk);
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("startup done", 32'h3, {30'h0, rd[4:3]});
    chk("ready bits", 32'h7, {29'h0, rd[26:24]});
    // live results from random levels
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      lvl <= seed[2:0];
      apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
      chk("results", {29'h0, seed[2:0]}, {29'h0, rd[18:16]});
    end
    // interrupt events, then zeros and single ones to the clear register
    @(posedge clk);
    ev <= 3'h7;
    @(posedge clk);
    ev <= 3'h0;
    pend = 5'h1f;
    apb(1'b1, acs_pkg::OFF_CLEAR, 32'h0);
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("zero clear", {27'h0, pend}, {27'h0, rd[4:0]});
    chk("irq set", 32'h1, {31'h0, irq});
    for (int i = 0; i < 5; i++) begin
      pend[i] = 1'b0;
      apb(1'b1, acs_pkg::OFF_CLEAR, 32'h1 << i);
      apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
      chk("one clear", {27'h0, pend}, {27'h0, rd[4:0]});
    end
    chk("irq clear", 32'h0, {31'h0, irq});
    // injected events, then a clear that meets a window event at its access edge
    apb(1'b1, acs_pkg::OFF_EVSET, 32'h15);
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("injected", 32'h15, {27'h0, rd[4:0]});
    fork
      apb(1'b1, acs_pkg::OFF_CLEAR, 32'h15);
      begin
        repeat (2) @(posedge clk);
        ev <= 3'h4;
        @(posedge clk);
        ev <= 3'h0;
      end
    join
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk("set wins", 32'h4, {27'h0, rd[4:0]});
    apb(1'b1, acs_pkg::OFF_CLEAR, 32'h4);
    // every select code on all four fields
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, acs_pkg::OFF_CTRL, 32'h1f | ({29'h0, c[2:0]} * 32'h0011_1100));
      chk("a pos", {25'h0, route_exp(2'h0, c[2:0])}, {25'h0, ap});
      chk("a neg", {25'h0, route_exp(2'h1, c[2:0])}, {25'h0, an});
      chk("b pos", {25'h0, route_exp(2'h2, c[2:0])}, {25'h0, bp});
      chk("b neg", {25'h0, route_exp(2'h3, c[2:0])}, {25'h0, bn});
    end
    apb(1'b0, acs_pkg::OFF_CTRL, 32'h0);
    chk("control", 32'h0077_771f, rd);
    complete_run();
  end
endmodule : acs_ctrl_tb
`default_nettype wire
